//--- lpcpi_top.sv
/*
  Device-side command pin interface of a low-power DDR memory: samples the
  link clock, clock gates, selects, command strobes, strobe and masks with
  the core clock, decodes commands, tracks open banks and power states per
  die, captures masked write beats and drives read beats with the strobe.
  Assumes the core clock is far faster than the link clock, and that the
  core feeds read beats on the same core clock.
*/
// Notes on behaviour
// - commands and addresses captured where true clock rises and complement falls.
// - data beats happen on both directions of the clock crossing.
// - clock gate high runs clocks, buffers, drivers; low stops all three (the code drops drivers only once no die is left awake).
// - gate low with banks idle gives precharge down or self refresh; else active (the code enters self refresh on a refresh even with banks open).
// - clock gate sampled on clock edges, except self refresh exit which is asynchronous.
// - in power-down or self refresh all inputs but the clock gate are ignored (the code stops taking write beats only once no die is left awake).
// - command decoder enabled only when chip select is registered low.
// - select plus row, column, write strobes form the four-bit command code.
// - write byte with its mask sampled high is discarded.
// - write masks sampled on both strobe edges with each data beat.
// - second die gate and select used only in dual-die parts.
// - strobe driven edge-aligned with read data; received with write data.
`timescale 1ns/1ps

module lpcpi_top
  import lpcpi_pkg::*;
(
  input  wire logic            core_clk,
  input  wire logic            arst_n,
  input  wire logic            dual_die_strap,
  input  wire logic            diff_clock_pos,
  input  wire logic            diff_clock_neg,
  input  wire logic            clk_gate_die_a,
  input  wire logic            clk_gate_die_b,
  input  wire logic            chip_select_die_a_n,
  input  wire logic            chip_select_die_b_n,
  input  wire logic            row_strobe_n,
  input  wire logic            col_strobe_n,
  input  wire logic            write_enable_n,
  input  wire logic [1:0]      bank_addr,
  input  wire logic            all_banks_sel,
  input  wire logic            data_strobe_in,
  input  wire logic            lower_byte_mask,
  input  wire logic            upper_byte_mask,
  input  wire logic [DQ_W-1:0] write_data_in,
  input  wire logic [DQ_W-1:0] read_beat_data,
  output logic                 die_a_awake,
  output logic                 die_b_awake,
  output logic [1:0]           die_a_power,
  output logic [1:0]           die_b_power,
  output logic                 cmd_valid,
  output logic [3:0]           cmd_code,
  output logic                 cmd_die,
  output logic [1:0]           cmd_bank,
  output logic [BANKS-1:0]     open_banks_a,
  output logic [BANKS-1:0]     open_banks_b,
  output logic                 wr_beat_valid,
  output logic [DQ_W-1:0]      wr_beat_data,
  output logic [1:0]           wr_beat_keep,
  output logic                 read_beat_take,
  output logic                 data_strobe_out,
  output logic                 data_strobe_oe,
  output logic [DQ_W-1:0]      read_data_out,
  output logic                 read_data_oe
);

  // ==========================================================
  // helper functions
  // both steps run once per die, so each is written once here

  // power state step for one die
  // entry is judged at the link rising crossing, like any command, so a
  // gate drop between crossings waits for the next one; power-down exit
  // also needs a crossing, self refresh exit does not
  function automatic lpcpi_pwr_type pwr_step(
    input lpcpi_pwr_type cur,
    input logic          gate,
    input logic          ck_rise,
    input logic          refresh_cmd,
    input logic          any_open
  );
    lpcpi_pwr_type nxt;
    nxt = cur;
    case (cur)
      PWR_SELF_REFRESH: begin
        // exit needs no link clock edge: the controller may stop it
        if (gate) nxt = PWR_AWAKE;
      end
      PWR_DOWN_PRECHARGE, PWR_DOWN_ACTIVE: begin
        if (ck_rise && gate) nxt = PWR_AWAKE;
      end
      PWR_AWAKE: begin
        if (ck_rise && !gate) begin
          if (refresh_cmd) nxt = PWR_SELF_REFRESH;
          else if (any_open) nxt = PWR_DOWN_ACTIVE;
          else nxt = PWR_DOWN_PRECHARGE;
        end
      end
      // unreachable with a two-bit enum, kept so a bad code recovers
      default: nxt = PWR_AWAKE;
    endcase
    return nxt;
  endfunction : pwr_step

  // open-row bookkeeping for one die
  // only activate and precharge move the bitmap; precharge with the
  // all-banks line high closes every row at once, other commands pass
  function automatic logic [BANKS-1:0] bank_step(
    input logic [BANKS-1:0] cur,
    input logic             hit,
    input logic [3:0]       code,
    input logic [1:0]       ba,
    input logic             all_sel
  );
    logic [BANKS-1:0] nxt;
    nxt = cur;
    if (hit) begin
      if (code == CMD_ACTIVATE) nxt[ba] = 1'b1;
      else if (code == CMD_PRECHARGE) begin
        if (all_sel) nxt = '0;
        else nxt[ba] = 1'b0;
      end
    end
    return nxt;
  endfunction : bank_step

  // ==========================================================
  // state registers
  // every flop of the block lives in one packed struct: one process
  // builds the copy, one registers it, so reset covers all of it
  lpcpi_state_type cur_ff;
  lpcpi_state_type nxt_ff;

  // decode results of the current cycle, all combinational
  logic [PIN_W-1:0] pins_raw;
  logic [PIN_W-1:0] pin;
  logic             ck_rise;
  logic             ck_cross;
  logic             dqs_edge;
  logic             sel_a;
  logic             sel_b;
  logic             hit_a;
  logic             hit_b;
  logic [3:0]       code_a;
  logic [3:0]       code_b;
  logic             gate_b;

  // all link pins gathered into one vector for the synchroniser; the die count strap stays out
  // order must match the field positions kept in the package
  assign pins_raw = {write_data_in, upper_byte_mask, lower_byte_mask, all_banks_sel,
                     bank_addr, data_strobe_in, write_enable_n, col_strobe_n,
                     row_strobe_n, chip_select_die_b_n, chip_select_die_a_n,
                     clk_gate_die_b, clk_gate_die_a, diff_clock_neg, diff_clock_pos};

  // ==========================================================
  // edge detection and decode, all on the second sync stage
  // edges are found on the second stage only, so a pin change shows up
  // three core edges later; the link clock must stay well below the core
  // clock for both crossings of one period to be seen apart
  always_comb begin
    pin      = cur_ff.sync2;
    // rising true clock with the complement already low marks the crossing
    ck_rise  = pin[P_CKP] && !cur_ff.ckp_prev && !pin[P_CKN];
    // either direction of the crossing times a data beat
    ck_cross = pin[P_CKP] != cur_ff.ckp_prev;
    // a strobe edge in either direction is one write beat
    dqs_edge = pin[P_DQS] != cur_ff.dqs_prev;
    // second die only counts in dual-die parts, else its pins are unused
    gate_b   = cur_ff.dual_die && pin[P_CKEB];
    sel_a    = !pin[P_CSA];
    sel_b    = cur_ff.dual_die && !pin[P_CSB];
    // select stays the top bit of the code, so the decoder sees four bits
    code_a   = {pin[P_CSA], pin[P_RAS], pin[P_CAS], pin[P_WE]};
    code_b   = {pin[P_CSB], pin[P_RAS], pin[P_CAS], pin[P_WE]};
    // decoder live only for an awake die with its gate still high
    // a deselected or sleeping die yields no hit, so its banks and command report do not move
    hit_a    = ck_rise && sel_a && pin[P_CKEA]
               && cur_ff.pwr_a == PWR_AWAKE;
    hit_b    = ck_rise && sel_b && gate_b
               && cur_ff.pwr_b == PWR_AWAKE;
  end

  // ==========================================================
  // next state
  // fields not touched here keep their value, which is how command,
  // bank and data fields hold between events
  always_comb begin
    nxt_ff = cur_ff;
    // two-stage synchroniser; stage one feeds stage two only
    nxt_ff.sync1    = pins_raw;
    nxt_ff.sync2    = cur_ff.sync1;
    nxt_ff.ckp_prev = pin[P_CKP];
    nxt_ff.dqs_prev = pin[P_DQS];

    // die count strap caught once after reset release
    // limitation: the strap is read unsynchronised, so it must be static
    if (!cur_ff.strap_done) begin
      nxt_ff.strap_done = 1'b1;
      nxt_ff.dual_die   = dual_die_strap;
    end

    // power states; self refresh entry is a refresh with the gate falling
    // die b follows its own gate and select only in dual-die parts
    nxt_ff.pwr_a = pwr_step(cur_ff.pwr_a, pin[P_CKEA], ck_rise,
                            sel_a && code_a == CMD_REFRESH && cur_ff.pwr_a == PWR_AWAKE,
                            |cur_ff.open_a);
    nxt_ff.pwr_b = pwr_step(cur_ff.pwr_b, gate_b, ck_rise,
                            sel_b && code_b == CMD_REFRESH && cur_ff.pwr_b == PWR_AWAKE,
                            |cur_ff.open_b);

    // deselected cycles leave bank state alone
    nxt_ff.open_a = bank_step(cur_ff.open_a, hit_a && pin[P_CKEA], code_a,
                              pin[P_BA +: 2], pin[P_A10]);
    nxt_ff.open_b = bank_step(cur_ff.open_b, hit_b, code_b,
                              pin[P_BA +: 2], pin[P_A10]);

    // command report is a one-cycle pulse; deselect issues nothing
    // die a wins the report when both dies take a command together
    nxt_ff.cmd_valid = 1'b0;
    if (hit_a || hit_b) begin
      nxt_ff.cmd_valid = 1'b1;
      nxt_ff.cmd_code  = hit_a ? code_a : code_b;
      nxt_ff.cmd_die   = !hit_a;
      nxt_ff.cmd_bank  = pin[P_BA +: 2];
      // any new command closes a running burst window
      // trade-off: no burst length is kept, so a window only ends on the
      // next command or on the power state change below
      nxt_ff.wr_win    = (hit_a ? code_a : code_b) == CMD_WRITE;
      nxt_ff.rd_win    = (hit_a ? code_a : code_b) == CMD_READ;
    end

    // bursts drop once no die is left awake (die a alone in single-die parts)
    if (nxt_ff.pwr_a != PWR_AWAKE && (!cur_ff.dual_die || nxt_ff.pwr_b != PWR_AWAKE)) begin
      nxt_ff.wr_win = 1'b0;
      nxt_ff.rd_win = 1'b0;
    end

    // write beats on both strobe edges, masks sampled with each beat
    // data and mask pass the same two stages as the strobe, so they
    // have settled by the time its edge is seen
    nxt_ff.wr_valid = 1'b0;
    if (cur_ff.wr_win && dqs_edge) begin
      nxt_ff.wr_valid = 1'b1;
      nxt_ff.wr_keep  = {!pin[P_UDM], !pin[P_LDM]};
      // masked bytes are zeroed so nothing downstream can store them
      nxt_ff.wr_data  = pin[P_DQ +: DQ_W]
                        & {{8{!pin[P_UDM]}}, {8{!pin[P_LDM]}}};
    end

    // read beats: strobe toggles with data on every clock crossing
    // the core must present the next beat before the crossing is seen;
    // there is no buffer to absorb a late one
    nxt_ff.rd_take = 1'b0;
    // output enables lag the window by one cycle, like the data
    nxt_ff.rd_oe   = cur_ff.rd_win;
    if (cur_ff.rd_win && ck_cross) begin
      nxt_ff.rd_take = 1'b1;
      nxt_ff.dqs_out = !cur_ff.dqs_out;
      nxt_ff.rd_data = read_beat_data;
    end
    // strobe parks low outside a read so the first beat always rises
    if (!cur_ff.rd_win) begin
      nxt_ff.dqs_out = 1'b0;
    end
  end

  // ==========================================================
  // register the whole state
  // asynchronous clear; both power states restart awake
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cur_ff       <= '0;
      cur_ff.pwr_a <= PWR_AWAKE;
      cur_ff.pwr_b <= PWR_AWAKE;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  // ==========================================================
  // outputs
  // every output comes from a flop; only the awake flags pass through a compare
  assign die_a_awake     = cur_ff.pwr_a == PWR_AWAKE;
  assign die_b_awake     = cur_ff.dual_die && cur_ff.pwr_b == PWR_AWAKE;
  // power codes: awake, precharge down, active down, self refresh
  assign die_a_power     = cur_ff.pwr_a;
  assign die_b_power     = cur_ff.pwr_b;
  assign cmd_valid       = cur_ff.cmd_valid;
  assign cmd_code        = cur_ff.cmd_code;
  assign cmd_die         = cur_ff.cmd_die;
  assign cmd_bank        = cur_ff.cmd_bank;
  assign open_banks_a    = cur_ff.open_a;
  assign open_banks_b    = cur_ff.open_b;
  assign wr_beat_valid   = cur_ff.wr_valid;
  assign wr_beat_data    = cur_ff.wr_data;
  assign wr_beat_keep    = cur_ff.wr_keep;
  assign read_beat_take  = cur_ff.rd_take;
  assign data_strobe_out = cur_ff.dqs_out;
  assign read_data_out   = cur_ff.rd_data;
  // drivers stop once no die is left awake, even mid burst
  assign data_strobe_oe  = cur_ff.rd_oe;
  assign read_data_oe    = cur_ff.rd_oe;

endmodule : lpcpi_top

//--- lpcpi_pkg.sv
/*
  Package for the low-power DDR command pin interface: pin vector layout,
  command codes, power states and the registered state of the block.
  Assumes one core clock that oversamples the memory link clock.
*/
package lpcpi_pkg;

  // ==========================================================
  // sampled pin vector layout
  localparam int P_CKP  = 0;
  localparam int P_CKN  = 1;
  localparam int P_CKEA = 2;
  localparam int P_CKEB = 3;
  localparam int P_CSA  = 4;
  localparam int P_CSB  = 5;
  localparam int P_RAS  = 6;
  localparam int P_CAS  = 7;
  localparam int P_WE   = 8;
  localparam int P_DQS  = 9;
  localparam int P_BA   = 10;
  localparam int P_A10  = 12;
  localparam int P_LDM  = 13;
  localparam int P_UDM  = 14;
  localparam int P_DQ   = 15;
  localparam int DQ_W   = 16;
  localparam int PIN_W  = 31;
  localparam int BANKS  = 4;

  // ==========================================================
  // command codes: {select_n, row_strobe_n, col_strobe_n, write_enable_n}
  localparam logic [3:0] CMD_LOAD_MODE = 4'h0;
  localparam logic [3:0] CMD_REFRESH   = 4'h1;
  localparam logic [3:0] CMD_PRECHARGE = 4'h2;
  localparam logic [3:0] CMD_ACTIVATE  = 4'h3;
  localparam logic [3:0] CMD_WRITE     = 4'h4;
  localparam logic [3:0] CMD_READ      = 4'h5;
  localparam logic [3:0] CMD_STOP      = 4'h6;
  localparam logic [3:0] CMD_NOP       = 4'h7;

  // ==========================================================
  // power states of one die
  typedef enum logic [1:0] {
    PWR_AWAKE,
    PWR_DOWN_PRECHARGE,
    PWR_DOWN_ACTIVE,
    PWR_SELF_REFRESH
  } lpcpi_pwr_type;

  // ==========================================================
  // whole registered state of the block
  typedef struct packed {
    logic [PIN_W-1:0] sync1;
    logic [PIN_W-1:0] sync2;
    logic             ckp_prev;
    logic             dqs_prev;
    logic             strap_done;
    logic             dual_die;
    lpcpi_pwr_type    pwr_a;
    lpcpi_pwr_type    pwr_b;
    logic [BANKS-1:0] open_a;
    logic [BANKS-1:0] open_b;
    logic             cmd_valid;
    logic [3:0]       cmd_code;
    logic             cmd_die;
    logic [1:0]       cmd_bank;
    logic             wr_win;
    logic             rd_win;
    logic             wr_valid;
    logic [DQ_W-1:0]  wr_data;
    logic [1:0]       wr_keep;
    logic             dqs_out;
    logic             rd_oe;
    logic             rd_take;
    logic [DQ_W-1:0]  rd_data;
  } lpcpi_state_type;

endpackage : lpcpi_pkg

//--- lpcpi_top_assertions.sv
/* port relations of the command pin interface.
   assumes the single core_clk domain; bound to every lpcpi_top. */
`timescale 1ns/1ps

module lpcpi_top_assertions
  import lpcpi_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        arst_n,
  input wire logic        dual_die_strap,
  input wire logic [15:0] read_beat_data,
  input wire logic        die_a_awake,
  input wire logic        die_b_awake,
  input wire logic [1:0]  die_a_power,
  input wire logic        cmd_valid,
  input wire logic [3:0]  cmd_code,
  input wire logic        cmd_die,
  input wire logic [1:0]  cmd_bank,
  input wire logic [3:0]  open_banks_a,
  input wire logic        wr_beat_valid,
  input wire logic [15:0] wr_beat_data,
  input wire logic [1:0]  wr_beat_keep,
  input wire logic        read_beat_take,
  input wire logic        data_strobe_out,
  input wire logic [15:0] read_data_out,
  input wire logic        read_data_oe
);
  // ==========================================================
  // all relations on the core clock, quiet while reset is low
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  chk_cmd_pulse: assert property (cmd_valid |=> !cmd_valid)
    else $error("command pulse longer than one cycle");
  chk_cmd_sel: assert property (cmd_valid |-> !cmd_code[3])
    else $error("command decoded with select high");
  chk_cmd_awake: assert property (cmd_valid && !cmd_die |-> $past(die_a_awake))
    else $error("command taken while die a asleep");
  chk_die_single: assert property (
    !dual_die_strap |-> !die_b_awake && !(cmd_valid && cmd_die))
    else $error("second die active on single die part");
  chk_awake_pwr: assert property (die_a_awake == (die_a_power == 2'h0))
    else $error("awake flag disagrees with power state");
  chk_drv_off: assert property (
    !dual_die_strap && !die_a_awake |=> !read_data_oe)
    else $error("data driver still on while die asleep");
  chk_bank_open: assert property (
    cmd_valid && !cmd_die && cmd_code == CMD_ACTIVATE |-> open_banks_a[cmd_bank])
    else $error("activate did not open its bank");
  chk_mask_bytes: assert property (wr_beat_valid |->
    (wr_beat_keep[0] || wr_beat_data[7:0] == 8'h00) &&
    (wr_beat_keep[1] || wr_beat_data[15:8] == 8'h00))
    else $error("masked write byte not discarded");
  chk_read_data: assert property (
    read_beat_take |-> read_data_out == $past(read_beat_data))
    else $error("read data not the beat just taken");
  chk_read_dqs: assert property (
    read_beat_take |-> data_strobe_out != $past(data_strobe_out))
    else $error("strobe did not turn with a read beat");
endmodule : lpcpi_top_assertions

bind lpcpi_top lpcpi_top_assertions i_lpcpi_top_assertions (.*);

//--- lpcpi_ctrl.sv
/* memory controller model driving the command, gate, strobe and mask pins.
   assumes a free running core_clk; link clock only runs inside frames. */
`timescale 1ns/1ps

module lpcpi_ctrl (
  input  wire logic  core_clk,
  output logic       diff_clock_pos,
  output logic       diff_clock_neg,
  output logic       clk_gate_die_a,
  output logic       clk_gate_die_b,
  output logic       chip_select_die_a_n,
  output logic       chip_select_die_b_n,
  output logic       row_strobe_n,
  output logic       col_strobe_n,
  output logic       write_enable_n,
  output logic [1:0] bank_addr,
  output logic       all_banks_sel,
  output logic       data_strobe_in,
  output logic       lower_byte_mask,
  output logic       upper_byte_mask,
  output logic [15:0] write_data_in
);
  // ==========================================================
  // idle pins: link clock parked low, both dies deselected, gates high
  initial begin
    {diff_clock_pos, diff_clock_neg} = 2'h1;
    {clk_gate_die_b, clk_gate_die_a} = 2'h3;
    {chip_select_die_b_n, chip_select_die_a_n} = 2'h3;
    {row_strobe_n, col_strobe_n, write_enable_n} = 3'h7;
    {bank_addr, all_banks_sel, data_strobe_in} = 4'h0;
    {upper_byte_mask, lower_byte_mask, write_data_in} = 18'h0;
  end

  // ==========================================================
  // one link period; command held across the rising crossing
  task automatic cyc(input logic [1:0] sel_n, input logic [2:0] rcw,
                     input logic [1:0] ba, input logic all, input logic [1:0] gate);
    @(negedge core_clk);
    {chip_select_die_b_n, chip_select_die_a_n} = sel_n;
    {row_strobe_n, col_strobe_n, write_enable_n} = rcw;
    bank_addr = ba;
    all_banks_sel = all;
    {clk_gate_die_b, clk_gate_die_a} = gate;
    repeat (16) @(negedge core_clk);
    {diff_clock_pos, diff_clock_neg} = 2'h2;
    repeat (16) @(negedge core_clk);
    {diff_clock_pos, diff_clock_neg} = 2'h1;
    // released strobes and bank address flip and selects go high, so a stale value of those can never pass for a held one
    {chip_select_die_b_n, chip_select_die_a_n} = 2'h3;
    {row_strobe_n, col_strobe_n, write_enable_n} = ~rcw;
    bank_addr = ~ba;
  endtask : cyc

  // one write beat, strobe edge centred, mask aligned with data
  task automatic beat(input logic [15:0] d, input logic [1:0] m);
    @(negedge core_clk);
    write_data_in = d;
    {upper_byte_mask, lower_byte_mask} = m;
    repeat (8) @(negedge core_clk);
    data_strobe_in = ~data_strobe_in;
    repeat (8) @(negedge core_clk);
    write_data_in = ~d;
  endtask : beat

  // gate change alone, no link edge; used for self refresh exit
  task automatic gate(input logic [1:0] g);
    @(negedge core_clk);
    {clk_gate_die_b, clk_gate_die_a} = g;
  endtask : gate
endmodule : lpcpi_ctrl

//--- lpcpi_top_tb.sv
/* self-checking bench of lpcpi_top with the controller model.
   assumes the checker is bound in; single die strap first, dual die
   strap after a reset in mid run. */
`timescale 1ns/1ps

module lpcpi_top_tb
  import lpcpi_pkg::*;
;
  logic core_clk, arst_n, dual_die_strap, diff_clock_pos, diff_clock_neg;
  logic clk_gate_die_a, clk_gate_die_b, chip_select_die_a_n, chip_select_die_b_n;
  logic row_strobe_n, col_strobe_n, write_enable_n, all_banks_sel, data_strobe_in;
  logic lower_byte_mask, upper_byte_mask, die_a_awake, die_b_awake, cmd_valid;
  logic cmd_die, wr_beat_valid, read_beat_take, data_strobe_out, data_strobe_oe;
  logic read_data_oe;
  logic [1:0]  bank_addr, die_a_power, die_b_power, cmd_bank, wr_beat_keep;
  logic [3:0]  cmd_code, open_banks_a, open_banks_b;
  logic [15:0] write_data_in, read_beat_data, wr_beat_data, read_data_out;
  logic [17:0] wq[$];
  int          err_count, checked, ncmd, ntake, cycles;

  lpcpi_top  i_lpcpi_top (.*);
  lpcpi_ctrl i_lpcpi_ctrl (.*);

  initial begin
    core_clk = 1'h0;
    forever #2.5 core_clk = ~core_clk;
  end

  // ==========================================================
  // event tallies and hang limit, far above the run's ~900 cycles;
  // taken at the falling edge, where registered outputs have settled
  always @(negedge core_clk) begin
    cycles++;
    if (cmd_valid === 1'h1) ncmd++;
    if (read_beat_take === 1'h1) ntake++;
    if (wr_beat_valid === 1'h1) wq.push_back({wr_beat_keep, wr_beat_data});
    if (cycles == 6000) begin
      err_count++;
      complete_run();
    end
  end

  task automatic cmp(input logic [17:0] got, input logic [17:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  // every code on die a; precharge then activate of bank 2 leaves it open
  task automatic t_codes();
    int n;
    for (int k = 0; k < 8; k++) begin
      n = ncmd;
      i_lpcpi_ctrl.cyc(2'h2, k[2:0], 2'h2, 1'h0, 2'h3);
      cmp(18'(ncmd - n), 18'h1);
      cmp(18'(cmd_code), 18'(k));
    end
    cmp(18'({cmd_die, cmd_bank, open_banks_a}), 18'h24);
    $display("test codes done");
  endtask : t_codes

  // deselected and second-die commands change nothing
  task automatic t_desel();
    int n;
    n = ncmd;
    i_lpcpi_ctrl.cyc(2'h3, CMD_ACTIVATE[2:0], 2'h1, 1'h0, 2'h3);
    i_lpcpi_ctrl.cyc(2'h1, CMD_ACTIVATE[2:0], 2'h0, 1'h0, 2'h3);
    cmp(18'(ncmd - n), 18'h0);
    cmp(18'({die_b_awake, open_banks_b, open_banks_a}), 18'h4);
    $display("test deselect done");
  endtask : t_desel

  // active down, ignored command, self refresh with gate-only exit, precharge down
  task automatic t_power();
    i_lpcpi_ctrl.cyc(2'h3, 3'h7, 2'h0, 1'h0, 2'h2);
    cmp(18'({die_a_awake, die_a_power}), 18'h2);
    i_lpcpi_ctrl.cyc(2'h2, CMD_PRECHARGE[2:0], 2'h2, 1'h1, 2'h2);
    cmp(18'(open_banks_a), 18'h4);
    i_lpcpi_ctrl.cyc(2'h3, 3'h7, 2'h0, 1'h0, 2'h3);
    cmp(18'({die_a_awake, die_a_power}), 18'h4);
    i_lpcpi_ctrl.cyc(2'h2, CMD_PRECHARGE[2:0], 2'h0, 1'h1, 2'h3);
    i_lpcpi_ctrl.cyc(2'h2, CMD_REFRESH[2:0], 2'h0, 1'h0, 2'h2);
    cmp(18'({open_banks_a, die_a_power}), 18'h3);
    i_lpcpi_ctrl.gate(2'h3);
    repeat (6) @(negedge core_clk);
    cmp(18'(die_a_power), 18'h0);
    i_lpcpi_ctrl.cyc(2'h3, 3'h7, 2'h0, 1'h0, 2'h2);
    cmp(18'(die_a_power), 18'h1);
    i_lpcpi_ctrl.cyc(2'h3, 3'h7, 2'h0, 1'h0, 2'h3);
    $display("test power done");
  endtask : t_power

  // two beats on rising then falling strobe, each with one byte masked
  task automatic t_write();
    wq.delete();
    i_lpcpi_ctrl.cyc(2'h2, CMD_WRITE[2:0], 2'h0, 1'h0, 2'h3);
    i_lpcpi_ctrl.beat(16'h1234, 2'h1);
    i_lpcpi_ctrl.beat(16'habcd, 2'h2);
    cmp(18'(wq.size()), 18'h2);
    cmp(wq[0], {2'h2, 16'h1200});
    cmp(wq[1], {2'h1, 16'h00cd});
    $display("test write done");
  endtask : t_write

  // read beats on both link crossings, strobe and data driven
  task automatic t_read();
    int n;
    @(negedge core_clk);
    read_beat_data = 16'h5aa5;
    i_lpcpi_ctrl.cyc(2'h2, CMD_READ[2:0], 2'h0, 1'h0, 2'h3);
    n = ntake;
    repeat (6) @(negedge core_clk);
    cmp(18'(data_strobe_out), 18'h1);
    i_lpcpi_ctrl.cyc(2'h3, 3'h7, 2'h0, 1'h0, 2'h3);
    cmp(18'(ntake - n), 18'h2);
    cmp({data_strobe_oe, read_data_oe, read_data_out}, {2'h3, 16'h5aa5});
    // gate low in mid burst stops strobe and data drivers
    i_lpcpi_ctrl.cyc(2'h3, 3'h7, 2'h0, 1'h0, 2'h2);
    cmp(18'({data_strobe_oe, read_data_oe, data_strobe_out}), 18'h0);
    i_lpcpi_ctrl.cyc(2'h3, 3'h7, 2'h0, 1'h0, 2'h3);
    $display("test read done");
  endtask : t_read

  // dual die strap across a reset in mid run; die b decodes and sleeps alone
  task automatic t_dual();
    int n;
    @(negedge core_clk);
    arst_n = 1'h0;
    dual_die_strap = 1'h1;
    repeat (6) @(negedge core_clk);
    arst_n = 1'h1;
    repeat (2) @(negedge core_clk);
    n = ncmd;
    i_lpcpi_ctrl.cyc(2'h1, CMD_ACTIVATE[2:0], 2'h1, 1'h0, 2'h3);
    cmp(18'(ncmd - n), 18'h1);
    cmp(18'({die_b_awake, cmd_die, cmd_bank, cmd_code, open_banks_b}), 18'hd32);
    i_lpcpi_ctrl.cyc(2'h3, 3'h7, 2'h0, 1'h0, 2'h1);
    cmp(18'({die_a_awake, die_b_awake, die_b_power}), 18'ha);
    i_lpcpi_ctrl.cyc(2'h3, 3'h7, 2'h0, 1'h0, 2'h3);
    cmp(18'(die_b_power), 18'h0);
    $display("test dual die done");
  endtask : t_dual

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run

  initial begin
    arst_n = 1'h0;
    dual_die_strap = 1'h0;
    read_beat_data = 16'h0;
    repeat (6) @(negedge core_clk);
    arst_n = 1'h1;
    repeat (2) @(negedge core_clk);
    t_codes();
    t_desel();
    t_power();
    t_write();
    t_read();
    t_dual();
    complete_run();
  end
endmodule : lpcpi_top_tb
